// ===== tb/boundary_scan_drive_control_tb_top.sv
// Purpose: Self-checking bench of the drive-select test logic
// Assumes: Tester model drives the test port
// Notes:   Run ends in close_out only
`timescale 1ns/10ps
`default_nettype none
`include "scan_map.svh"

module boundary_scan_drive_control_tb_top;
    import scan_pkg::*;
    logic       mclk, nrst, tck, tms, tdi, trst_n, rst_in_n, tdo, tdo_oe;
    logic       owns, keep, ireset, highz, bwait, oe;
    logic [2:0] ipl;
    bsr_vec_t   cap, upd, drv, dout, u0, ctl_mask;
    bsr_vec_t   pat_a, pat_b, pat_c;
    int         fail_count, compares, cyc, waits, w;

    drive_scan_tap dut (
        .mclk(mclk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .reset_input_n(rst_in_n),
        .interrupt_priority_pins(ipl), .cell_capture(cap), .tdo(tdo),
        .tdo_oe(tdo_oe), .bsr_update_q(upd), .drive_small_q(drv),
        .test_owns_pins_q(owns), .keepalive_en_q(keep),
        .int_reset_q(ireset), .force_highz_q(highz), .sys_bus_wait_q(bwait)
    );
    scan_tester tester (
        .mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n)
    );

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // Hang guard: tests need about 14000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        waits <= waits + int'(bwait === 1'b1);
        if (cyc == 60000) begin
            fail_count++;
            close_out;
        end
    end

    task chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    function automatic bsr_vec_t pin_map(input logic [2:0] p);
        for (int i = 0; i < `BSR_LEN; i++) begin
            pin_map[i] = (i < `ADDR_CELL_LO || i > `DATA_CELL_HI) ? p[2] :
                         (i <= `ADDR_CELL_HI) ? p[0] : p[1];
        end
    endfunction

    function automatic bsr_vec_t cap_exp(input bsr_vec_t u);
        cap_exp = (cap & ~ctl_mask) | (u & ctl_mask);
    endfunction

    task load_ir(input instr_t c);
        tester.shift(1'b1, 3, bsr_vec_t'(c), dout, oe);
        chk(dout[2:0] === 3'b001 && oe === 1'b1, "ir capture");
    endtask

    task sys_negate(input logic [2:0] p);
        @(posedge mclk);
        ipl <= p;
        rst_in_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_in_n <= 1'b1;
        repeat (140) @(posedge mclk);
    endtask

    task sc_bypass;
        load_ir(`IR_BYPASS);
        tester.shift(1'b0, 4, bsr_vec_t'(4'hb), dout, oe);
        chk(dout[3:0] === 4'h6, "bypass path");
        chk(oe === 1'b1 && tdo_oe === 1'b0, "tdo enable");
    endtask

    task sc_reset_load;
        sys_negate(3'b101);
        chk(drv === pin_map(3'b101), "latch from pins");
    endtask

    task sc_sys_drive;
        load_ir(`IR_DRV_SYS);
        chk({owns, keep, ireset} === 3'b000, "system select flags");
        u0 = upd;
        w = waits;
        tester.shift(1'b0, `BSR_LEN, pat_a, dout, oe);
        chk(dout === cap_exp(u0), "output cell capture");
        chk(drv === pat_a && upd === u0, "system update");
        chk(waits == w + 1, "bus wait pulse");
        sys_negate(3'b010);
        chk(drv === pin_map(3'b010), "reload on negation");
    endtask

    task sc_test_drive;
        load_ir(`IR_SAMPLE);
        tester.shift(1'b0, `BSR_LEN, pat_b, dout, oe);
        chk(upd === pat_b, "preload");
        load_ir(`IR_DRV_TEST);
        chk({owns, keep, ireset} === 3'b111, "test select flags");
        tester.shift(1'b0, `BSR_LEN, pat_c, dout, oe);
        chk(dout === cap_exp(pat_b), "capture");
        chk(drv === pat_c && upd === pat_c, "test update");
        sys_negate(3'b111);
        chk(drv === pat_c, "negation ignored");
        load_ir(`IR_EXTEST);
        chk(drv === pat_c, "held under extest");
        load_ir(`IR_SHUTDOWN);
        tester.shift(1'b0, 2, bsr_vec_t'(2'h3), dout, oe);
        chk(dout[1:0] === 2'b10 && keep === 1'b1, "shutdown path");
        chk(owns === 1'b1 && ireset === 1'b1, "shutdown flags");
        chk(drv === pat_c && upd === pat_c, "clamp held");
        load_ir(`IR_PRIVATE);
        chk(owns === 1'b0 && drv === pin_map(3'b010), "private");
    endtask

    task sc_tlr;
        load_ir(`IR_DRV_TEST);
        tester.shift(1'b0, `BSR_LEN, pat_a, dout, oe);
        chk(drv === pat_a, "test drive again");
        tester.reset_tap;
        chk(owns === 1'b0 && drv === pin_map(3'b010), "system regains");
        chk((upd & ctl_mask) === '0, "control cells cleared");
        tester.shift(1'b0, 2, bsr_vec_t'(2'h1), dout, oe);
        chk(dout[1:0] === 2'b10, "bypass after reset");
        load_ir(`IR_HIGHZ);
        chk(highz === 1'b1 && owns === 1'b1, "highz flags");
        chk(drv === pin_map(3'b010), "highz system drive");
    endtask

    task close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        rst_in_n = 1'b1;
        ipl = 3'h0;
        cap = {23{8'ha5}};
        pat_a = {23{8'h3c}};
        pat_b = {23{8'h96}};
        pat_c = {23{8'h5a}};
        ctl_mask = '0;
        ctl_mask[`CTRL_ADDR_BIT] = 1'b1;
        ctl_mask[`CTRL_DATA_BIT] = 1'b1;
        ctl_mask[`CTRL_MISC2_BIT +: 3] = 3'h7;
        fail_count = 0;
        compares = 0;
        cyc = 0;
        waits = 0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(drv === '0 && owns === 1'b0, "reset values");
        // Shift tasks start from run-test/idle
        tester.reset_tap;
        sc_bypass;
        sc_reset_load;
        sc_sys_drive;
        sc_test_drive;
        sc_tlr;
        close_out;
    end
endmodule // boundary_scan_drive_control_tb_top

`default_nettype wire

// ===== tb/drive_scan_tap_properties.sv
// Purpose: Port-level properties of the drive-select test logic
// Assumes: Test clock far slower than mclk, pins held a few cycles
// Notes:   Bound to every drive_scan_tap instance below
`timescale 1ns/10ps
`default_nettype none
`include "scan_map.svh"

module drive_scan_tap_properties (
    input wire logic               mclk,
    input wire logic               nrst,
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tdi,
    input wire logic               trst_n,
    input wire logic               reset_input_n,
    input wire logic [2:0]         interrupt_priority_pins,
    input wire scan_pkg::bsr_vec_t cell_capture,
    input wire logic               tdo,
    input wire logic               tdo_oe,
    input wire scan_pkg::bsr_vec_t bsr_update_q,
    input wire scan_pkg::bsr_vec_t drive_small_q,
    input wire logic               test_owns_pins_q,
    input wire logic               keepalive_en_q,
    input wire logic               int_reset_q,
    input wire logic               force_highz_q,
    input wire logic               sys_bus_wait_q
);
    import scan_pkg::*;
    logic [3:0] trst_low_q;
    logic [3:0] trst_low_d;
    bsr_vec_t   pin_map;

    // Saturating count of test reset low cycles
    always_comb begin
        trst_low_d = trst_n ? 4'h0 : trst_low_q + {3'h0, trst_low_q != 4'hf};
        for (int i = 0; i < `BSR_LEN; i++) begin
            pin_map[i] = (i < `ADDR_CELL_LO || i > `DATA_CELL_HI) ?
                interrupt_priority_pins[2] : (i <= `ADDR_CELL_HI) ?
                interrupt_priority_pins[0] : interrupt_priority_pins[1];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trst_low_q <= 4'h0;
        end else begin
            trst_low_q <= trst_low_d;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence sys_negation;
        $rose(reset_input_n) && !test_owns_pins_q;
    endsequence
    sequence pins_loaded;
        ##[3:6] drive_small_q == pin_map;
    endsequence

    a_owner_flags: assert property (
        keepalive_en_q == test_owns_pins_q && int_reset_q == test_owns_pins_q)
        else $error("keep-alive or reset flag differs from ownership");
    a_wait_one_pulse: assert property (
        sys_bus_wait_q |=> !sys_bus_wait_q)
        else $error("bus wait longer than one cycle");
    a_wait_system_owned: assert property (
        sys_bus_wait_q |-> !test_owns_pins_q)
        else $error("bus wait while test logic owns pins");
    a_tdo_after_fall: assert property (
        $changed(tdo) || $changed(tdo_oe) |-> !$past(tck, 1) && !$past(tck, 2))
        else $error("serial output moved outside a low test clock");
    a_drive_has_cause: assert property (
        $changed(drive_small_q) |-> $past(tck, 1) || !(&{$past(trst_n, 1),
        $past(reset_input_n, 3), $past(reset_input_n, 4),
        $past(reset_input_n, 5)}))
        else $error("driver choice changed without cause");
    a_update_has_cause: assert property (
        $changed(bsr_update_q) |-> $past(tck, 1) || !$past(trst_n, 1))
        else $error("update cells changed without cause");
    a_trst_clears_cells: assert property (
        trst_low_q == 4'ha |-> !test_owns_pins_q && !force_highz_q &&
        {bsr_update_q[`CTRL_ADDR_BIT], bsr_update_q[`CTRL_DATA_BIT],
        bsr_update_q[`CTRL_MISC2_BIT +: 3]} == 5'h0)
        else $error("test reset left control cells or ownership set");
    a_negation_loads: assert property (
        sys_negation |-> pins_loaded)
        else $error("reset negation did not load priority pins");
endmodule // drive_scan_tap_properties

bind drive_scan_tap drive_scan_tap_properties chk (
    .mclk, .nrst, .tck, .tms, .tdi, .trst_n, .reset_input_n,
    .interrupt_priority_pins, .cell_capture, .tdo, .tdo_oe,
    .bsr_update_q, .drive_small_q, .test_owns_pins_q, .keepalive_en_q,
    .int_reset_q, .force_highz_q, .sys_bus_wait_q
);

`default_nettype wire

// ===== tb/scan_tester.sv
// Purpose: Boundary-scan tester model on the test port
// Assumes: 160 ns test clock, stopped low between frames
// Notes:   Tasks are called from the bench top
`timescale 1ns/10ps
`default_nettype none

module scan_tester (
    input  wire logic mclk,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n
);
    import scan_pkg::*;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end

    // change on fall, sample on rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge mclk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge mclk);
        tck <= 1'b1;
        o = tdo;
        repeat (7) @(posedge mclk);
    endtask

    task automatic shift(input logic ir, input int n, input bsr_vec_t din,
                         output bsr_vec_t dout, output logic oe);
        logic o;
        dout = '0;
        oe = 1'b1;
        step(1'b1, 1'b1, o);
        if (ir) begin
            step(1'b1, 1'b1, o);
        end
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
            oe = oe & tdo_oe;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        // Clock stands still; tdi floats to pull-up, tms stays low
        @(posedge mclk);
        tck <= 1'b0;
        tdi <= 1'b1;
    endtask

    task automatic reset_tap;
        logic o;
        @(posedge mclk);
        trst_n <= 1'b0;
        repeat (14) @(posedge mclk);
        trst_n <= 1'b1;
        step(1'b0, 1'b1, o);
        @(posedge mclk);
        tck <= 1'b0;
    endtask
endmodule // scan_tester

`default_nettype wire

// ===== verilog/drive_scan_tap.sv
// Purpose: Test access logic with output driver selection
// Assumes: Test port pins sampled by mclk, far faster than tck
// Notes:   Pin muxing outside uses the update cells and ownership flag
//
// Overview of operation
// - Test drive select: zero large, one small
// - Test drive select captures like external test
// - Test drive select: keep-alive, reset, test owns
// - Reset negation under system control loads latches from priority pins
// - Update-DR under test select replaces latches
// - Held only under three instructions, else system
// - Test-logic-reset gives bypass, system regains drive
// - Shutdown: reset, keep-alive, bypass, test owns
// - Preload then shutdown clamps pins
// - Private instruction leaves pins as system
// - System drive select updates latches in update-DR
// - System drive select: no keep-alive, no reset
// - Later reset negation may reload latches
// - Bus may wait during system latch update
// - Bypass is a one-bit path
// - Bypass stage clears in capture-DR
// - Chain of 184 cells, bit zero first
// - Output cells capture internal output latch
// - Five control cells, one enables output
// - Control cells capture own value, clear at reset
// - Control cells at 150, 151, 154, 155, 156
// - Three-bit codes, bit zero shifted first
// - Sample on rise, data out on fall
`timescale 1ns/10ps
`default_nettype none
`include "scan_map.svh"

module drive_scan_tap (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic             trst_n,
    input  wire logic             reset_input_n,
    input  wire logic [2:0]       interrupt_priority_pins,
    input  wire scan_pkg::bsr_vec_t cell_capture,
    output logic                  tdo,
    output logic                  tdo_oe,
    output scan_pkg::bsr_vec_t    bsr_update_q,
    output scan_pkg::bsr_vec_t    drive_small_q,
    output logic                  test_owns_pins_q,
    output logic                  keepalive_en_q,
    output logic                  int_reset_q,
    output logic                  force_highz_q,
    output logic                  sys_bus_wait_q
);
    import scan_pkg::*;

    typedef struct packed {
        tap_state_t tap;
        instr_t     ir_sh;
        instr_t     ir;
        logic       byp;
        bsr_vec_t   bsr_sh;
        bsr_vec_t   bsr_upd;
        bsr_vec_t   sys_drv;
        bsr_vec_t   test_drv;
        bsr_vec_t   drv_out;
        logic       test_hold;
        logic       rst_prev;
        logic       tdo;
        logic       tdo_oe;
        logic       test_pins;
        logic       keepalive;
        logic       int_rst;
        logic       highz;
        logic       bus_wait;
    } tap_regs_t;

    tap_regs_t  r_q;
    tap_regs_t  r_d;
    bsr_vec_t   ctrl_mask;
    bsr_vec_t   cap_vec;
    bsr_vec_t   ipl_vec;
    pin_sync_if sync ();

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    pin_sync u_pin_sync (
        .mclk          (mclk),
        .nrst          (nrst),
        .tck           (tck),
        .tms           (tms),
        .tdi           (tdi),
        .trst_n        (trst_n),
        .reset_input_n (reset_input_n),
        .sync          (sync.src)
    );

    // ------------------------------------------------------------------
    // Per-cell capture source and latch preload
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `BSR_LEN; gi = gi + 1) begin : g_cell
            assign ctrl_mask[gi] = (gi == `CTRL_ADDR_BIT)
                                || (gi == `CTRL_DATA_BIT)
                                || (gi == `CTRL_MISC2_BIT)
                                || (gi == `CTRL_MISC1_BIT)
                                || (gi == `CTRL_MISC0_BIT);
            assign cap_vec[gi] = ctrl_mask[gi] ? r_q.bsr_upd[gi]
                                               : cell_capture[gi];
            // One latch per cell, grouped by bus
            if (gi >= `ADDR_CELL_LO && gi <= `ADDR_CELL_HI) begin : g_a
                assign ipl_vec[gi] = interrupt_priority_pins[0];
            end else if (gi >= `DATA_CELL_LO && gi <= `DATA_CELL_HI)
            begin : g_d
                assign ipl_vec[gi] = interrupt_priority_pins[1];
            end else begin : g_m
                assign ipl_vec[gi] = interrupt_priority_pins[2];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Controller state transitions
    // ------------------------------------------------------------------
    function automatic tap_state_t tap_next(tap_state_t s, logic m);
        case (s)
            TLR:     tap_next = m ? TLR   : RTI;
            RTI:     tap_next = m ? SELDR : RTI;
            SELDR:   tap_next = m ? SELIR : CAPDR;
            CAPDR:   tap_next = m ? EX1DR : SHDR;
            SHDR:    tap_next = m ? EX1DR : SHDR;
            EX1DR:   tap_next = m ? UPDR  : PADR;
            PADR:    tap_next = m ? EX2DR : PADR;
            EX2DR:   tap_next = m ? UPDR  : SHDR;
            UPDR:    tap_next = m ? SELDR : RTI;
            SELIR:   tap_next = m ? TLR   : CAPIR;
            CAPIR:   tap_next = m ? EX1IR : SHIR;
            SHIR:    tap_next = m ? EX1IR : SHIR;
            EX1IR:   tap_next = m ? UPIR  : PAIR;
            PAIR:    tap_next = m ? EX2IR : PAIR;
            EX2IR:   tap_next = m ? UPIR  : SHIR;
            UPIR:    tap_next = m ? SELDR : RTI;
            default: tap_next = TLR;
        endcase
    endfunction

    function automatic logic uses_bsr(instr_t i);
        uses_bsr = (i == `IR_EXTEST) || (i == `IR_SAMPLE)
                || (i == `IR_DRV_TEST) || (i == `IR_DRV_SYS);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_d          = r_q;
        r_d.bus_wait = 1'b0;
        r_d.rst_prev = sync.rst_in_n;

        if (!sync.trst_n) begin
            r_d.tap = TLR;
        end else if (sync.tck_rise) begin
            r_d.tap = tap_next(r_q.tap, sync.tms);
            case (r_q.tap)
                CAPIR: r_d.ir_sh = `IR_CAPTURE_VAL;
                SHIR:  r_d.ir_sh = {sync.tdi, r_q.ir_sh[`IR_LEN-1:1]};
                UPIR:  r_d.ir = r_q.ir_sh;
                CAPDR: begin
                    r_d.byp = 1'b0;
                    if (uses_bsr(r_q.ir)) begin
                        r_d.bsr_sh = cap_vec;
                    end
                end
                SHDR: begin
                    if (uses_bsr(r_q.ir)) begin
                        r_d.bsr_sh = {sync.tdi,
                                      r_q.bsr_sh[`BSR_LEN-1:1]};
                    end else begin
                        r_d.byp = sync.tdi;
                    end
                end
                UPDR: begin
                    if (r_q.ir == `IR_EXTEST || r_q.ir == `IR_SAMPLE
                        || r_q.ir == `IR_DRV_TEST) begin
                        r_d.bsr_upd = r_q.bsr_sh;
                    end
                    if (r_q.ir == `IR_DRV_TEST) begin
                        r_d.test_drv  = r_q.bsr_sh;
                        r_d.test_hold = 1'b1;
                    end
                    if (r_q.ir == `IR_DRV_SYS && !r_q.test_pins) begin
                        r_d.sys_drv  = r_q.bsr_sh;
                        r_d.bus_wait = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (r_d.tap == TLR) begin
            r_d.ir    = `IR_RESET_VAL;
            r_d.ir_sh = `IR_RESET_VAL;
            r_d.bsr_upd[`CTRL_ADDR_BIT]  = 1'b0;
            r_d.bsr_upd[`CTRL_DATA_BIT]  = 1'b0;
            r_d.bsr_upd[`CTRL_MISC2_BIT] = 1'b0;
            r_d.bsr_upd[`CTRL_MISC1_BIT] = 1'b0;
            r_d.bsr_upd[`CTRL_MISC0_BIT] = 1'b0;
        end

        // Hold only under the three test instructions
        if (r_d.ir != `IR_DRV_TEST && r_d.ir != `IR_EXTEST
            && r_d.ir != `IR_SHUTDOWN) begin
            r_d.test_hold = 1'b0;
        end

        // Test select takes pins, clock, reset
        // Private and system select leave pins
        r_d.test_pins = (r_d.ir == `IR_EXTEST) || (r_d.ir == `IR_HIGHZ)
                     || (r_d.ir == `IR_DRV_TEST)
                     || (r_d.ir == `IR_SHUTDOWN);
        r_d.keepalive = r_d.test_pins;
        r_d.int_rst   = r_d.test_pins;
        r_d.highz     = (r_d.ir == `IR_HIGHZ);

        // Load on reset negation under system control
        if (sync.rst_in_n && !r_q.rst_prev && !r_q.test_pins) begin
            r_d.sys_drv = ipl_vec;
        end

        r_d.drv_out = r_d.test_hold ? r_d.test_drv : r_d.sys_drv;

        if (sync.tck_fall) begin
            r_d.tdo_oe = (r_q.tap == SHIR) || (r_q.tap == SHDR);
            if (r_q.tap == SHIR) begin
                r_d.tdo = r_q.ir_sh[0];
            end else if (uses_bsr(r_q.ir)) begin
                r_d.tdo = r_q.bsr_sh[0];
            end else begin
                r_d.tdo = r_q.byp;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Drive latches come up large; priority pins set them only at reset input negation
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r_q           <= '0;
            r_q.tap       <= TLR;
            r_q.ir        <= `IR_RESET_VAL;
            r_q.ir_sh     <= `IR_RESET_VAL;
            // Reset pin idles high; no false negation after release
            r_q.rst_prev  <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign tdo              = r_q.tdo;
    assign tdo_oe           = r_q.tdo_oe;
    assign bsr_update_q     = r_q.bsr_upd;
    assign drive_small_q    = r_q.drv_out;
    assign test_owns_pins_q = r_q.test_pins;
    assign keepalive_en_q   = r_q.keepalive;
    assign int_reset_q      = r_q.int_rst;
    assign force_highz_q    = r_q.highz;
    assign sys_bus_wait_q   = r_q.bus_wait;

endmodule // drive_scan_tap

`default_nettype wire

// ===== verilog/pin_sync.sv
// Purpose: Two-stage synchronisers and test clock edge detection
// Assumes: All inputs are asynchronous pins
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
    input  wire logic  mclk,
    input  wire logic  nrst,
    input  wire logic  tck,
    input  wire logic  tms,
    input  wire logic  tdi,
    input  wire logic  trst_n,
    input  wire logic  reset_input_n,
    pin_sync_if.src    sync
);
    import scan_pkg::*;

    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] stab;
        logic       tck_prev;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;
    logic [4:0]  raw;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    assign raw = {reset_input_n, trst_n, tdi, tms, tck};

    always_comb begin
        st_d          = st_q;
        st_d.meta     = raw;
        st_d.stab     = st_q.meta;
        st_d.tck_prev = st_q.stab[0];
    end

    // Pins with pullups idle high
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{meta: 5'h1e, stab: 5'h1e, tck_prev: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync.tck_rise = st_q.stab[0] & ~st_q.tck_prev;
    assign sync.tck_fall = ~st_q.stab[0] & st_q.tck_prev;
    assign sync.tms      = st_q.stab[1];
    assign sync.tdi      = st_q.stab[2];
    assign sync.trst_n   = st_q.stab[3];
    assign sync.rst_in_n = st_q.stab[4];

endmodule // pin_sync

`default_nettype wire

// ===== verilog/pin_sync_if.sv
// Purpose: Carries synchronised test port levels and clock edges
// Assumes: One clock domain, mclk
// Notes:   Filled by pin_sync, read by the top
`timescale 1ns/10ps
`default_nettype none

interface pin_sync_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst_n;
    logic rst_in_n;
    modport src (output tck_rise, tck_fall, tms, tdi, trst_n, rst_in_n);
    modport dst (input  tck_rise, tck_fall, tms, tdi, trst_n, rst_in_n);
endinterface // pin_sync_if

`default_nettype wire

// ===== verilog/scan_map.svh
// Purpose: Offsets, field positions and codes of the test access logic
// Assumes: Included by the package and by the design files
// Notes:   Definitions only
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH

// ------------------------------------------------------------------
// Chain geometry
// ------------------------------------------------------------------
`define BSR_LEN         184
`define IR_LEN          3
`define CTRL_ADDR_BIT   150
`define CTRL_DATA_BIT   151
`define CTRL_MISC2_BIT  154
`define CTRL_MISC1_BIT  155
`define CTRL_MISC0_BIT  156
`define ADDR_CELL_LO    9
`define ADDR_CELL_HI    52
`define DATA_CELL_LO    53
`define DATA_CELL_HI    149

// ------------------------------------------------------------------
// Instruction codes and reset values
// ------------------------------------------------------------------
`define IR_EXTEST       3'h0
`define IR_HIGHZ        3'h1
`define IR_SAMPLE       3'h2
`define IR_DRV_TEST     3'h3
`define IR_SHUTDOWN     3'h4
`define IR_PRIVATE      3'h5
`define IR_DRV_SYS      3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1
`define IR_RESET_VAL    3'h7

`endif

// ===== verilog/scan_pkg.sv
// Purpose: Types shared by the test access logic
// Assumes: scan_map.svh holds the numbers
// Notes:   Types only
`include "scan_map.svh"

package scan_pkg;

    typedef enum logic [3:0] {
        TLR   = 4'h0, RTI   = 4'h1, SELDR = 4'h2, CAPDR = 4'h3,
        SHDR  = 4'h4, EX1DR = 4'h5, PADR  = 4'h6, EX2DR = 4'h7,
        UPDR  = 4'h8, SELIR = 4'h9, CAPIR = 4'ha, SHIR  = 4'hb,
        EX1IR = 4'hc, PAIR  = 4'hd, EX2IR = 4'he, UPIR  = 4'hf
    } tap_state_t;

    typedef logic [`IR_LEN-1:0]  instr_t;
    typedef logic [`BSR_LEN-1:0] bsr_vec_t;

endpackage
